// >>> verilog/fsu_top.sv
// Floating-point subtract datapath with parallel move, register file and bus slave
`timescale 1ns/10ps
`default_nettype none
`include "fsu_params.svh"

module fsu_top
(
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire logic                issue_valid,
  input  wire fsu_pkg::fsu_instr_t instr,
  input  wire logic [31:0]         load_data,
  output var fsu_pkg::fsu_store_t  store,
  output logic [10:0]              float_status_register,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  output logic                     irq
);

  // Subtract with flush-to-zero of denormal inputs; returns {ovf, unf, result}
  function automatic logic [33:0] fp_sub
  (
    input logic [31:0] x,
    input logic [31:0] y,
    input logic        rnd
  );
    logic              same;
    logic [31:0]       yn;
    logic [31:0]       big;
    logic [31:0]       sml;
    logic [7:0]        d;
    logic [27:0]       mb;
    logic [27:0]       ms;
    logic [27:0]       sum;
    logic signed [9:0] e;
    logic              ov;
    logic              un;
    logic [31:0]       r;
    yn = {~y[31], y[30:0]};
    if (x[30:0] < yn[30:0])
    begin
      big = yn;
      sml = x;
    end
    else
    begin
      big = x;
      sml = yn;
    end
    same = big[31] == sml[31];
    d = big[30:23] - sml[30:23];
    mb = (big[30:23] == 8'h00) ? 28'h0 : {2'b01, big[22:0], 3'h0};
    ms = (sml[30:23] == 8'h00) ? 28'h0 : {2'b01, sml[22:0], 3'h0};
    // Sticky bit dropped: alignment loss only affects the last ulp
    ms = (d > `FSU_SHIFT_MAX) ? 28'h0 : ms >> d;
    sum = same ? mb + ms : mb - ms;
    e = signed'({2'b00, big[30:23]});
    if (sum[27])
    begin
      sum = sum >> 1;
      e = e + 10'sd1;
    end
    for (int i = 0; i < 26; i++)
    begin
      if (sum != 28'h0 && !sum[26])
      begin
        sum = sum << 1;
        e = e - 10'sd1;
      end
    end
    // Round-to-nearest only when the rounding mode flag asks for it
    if (rnd && sum[2])
    begin
      sum = sum + 28'h8;
      if (sum[27])
      begin
        sum = sum >> 1;
        e = e + 10'sd1;
      end
    end
    ov = 1'b0;
    un = 1'b0;
    if (sum == 28'h0)
      r = 32'h0;
    else if (e >= `FSU_EXP_INF)
    begin
      ov = 1'b1;
      r = {big[31], `FSU_FP_MAX};
    end
    else if (e <= 10'sd0)
    begin
      un = 1'b1;
      r = {big[31], 31'h0};
    end
    else
      r = {big[31], e[7:0], sum[25:3]};
    return {ov, un, r};
  endfunction

  logic [31:0]         rf [0:7];
  logic [31:0]         next_rf [0:7];
  fsu_pkg::fsu_pipe_t  pipe;
  fsu_pkg::fsu_pipe_t  next_pipe;
  fsu_pkg::fsu_store_t next_store;
  logic [10:0]         next_stf;
  logic [1:0]          int_stat;
  logic [1:0]          int_en;
  logic                dph_wr;
  logic                dph_rd;
  logic                rd_done;
  logic [7:0]          dph_off;

  // Instruction decode
  wire fsu_pkg::fsu_op_t op;
  wire is_rr    = instr.lsw == `FSU_LSW_RR && instr.msw[15:9] == `FSU_MSW_RR_ZERO;
  wire is_imm   = instr.lsw[15:6] == `FSU_IMM_TOP;
  wire is_load  = instr.lsw[15:4] == `FSU_LOAD_TOP;
  wire is_store = instr.lsw[15:4] == `FSU_STORE_TOP;
  wire is_par   = is_load || is_store;

  assign op = !issue_valid ? fsu_pkg::FSU_OP_NONE  :
              is_rr        ? fsu_pkg::FSU_OP_RR    :
              is_imm       ? fsu_pkg::FSU_OP_IMM   :
              is_load      ? fsu_pkg::FSU_OP_LOAD  :
              is_store     ? fsu_pkg::FSU_OP_STORE :
                             fsu_pkg::FSU_OP_NONE;

  // Selector fields per form
  wire [2:0]  sel_rr_min  = instr.msw[5:3];
  wire [2:0]  sel_rr_sub  = instr.msw[8:6];
  wire [2:0]  sel_low_dst = instr.msw[2:0];
  wire [2:0]  sel_par_min = {instr.lsw[0], instr.msw[15:14]};
  wire [2:0]  sel_par_sub = instr.lsw[3:1];
  wire [2:0]  sel_par_dst = instr.msw[13:11];
  wire [2:0]  sel_move    = instr.msw[10:8];
  wire [7:0]  mem_field   = instr.msw[7:0];
  wire [15:0] imm_hi      = {instr.lsw[5:0], instr.msw[15:6]};

  wire [2:0]  sel_min = is_par ? sel_par_min : sel_rr_min;
  wire [2:0]  sel_sub = is_par ? sel_par_sub : (is_imm ? sel_rr_min : sel_rr_sub);
  wire [2:0]  sel_dst = is_par ? sel_par_dst : sel_low_dst;

  // Minuend for the immediate form has a zero low half
  wire [31:0] imm_word = {imm_hi, 16'h0000};

  // First pipeline stage captures operands
  always_comb
  begin
    next_pipe.valid      = op != fsu_pkg::FSU_OP_NONE;
    next_pipe.dest       = sel_dst;
    next_pipe.minuend    = is_imm ? imm_word : rf[sel_min];
    next_pipe.subtrahend = rf[sel_sub];
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      pipe <= '0;
    else
      pipe <= next_pipe;
  end

  // Second stage computes and writes back
  wire [33:0] sub_out  = fp_sub(pipe.minuend, pipe.subtrahend, float_status_register[`FSU_BIT_RND]);
  wire [31:0] sub_res  = sub_out[31:0];
  wire        ev_unf   = pipe.valid && sub_out[32];
  wire        ev_ovf   = pipe.valid && sub_out[33];
  wire        load_wr  = op == fsu_pkg::FSU_OP_LOAD;

  // Bus side decode
  wire        addr_phase = hsel && htrans[1] && hready && hsize == `FSU_AHB_WORD;
  wire        bus_wr     = dph_wr && hready;
  wire        sw_reg_wr  = bus_wr && dph_off < `FSU_OFF_STATUS;
  wire        sw_stf_wr  = bus_wr && dph_off == `FSU_OFF_STATUS;
  wire        sw_en_wr   = bus_wr && dph_off == `FSU_OFF_INT_EN;
  wire [1:0]  sw_clr     = (bus_wr && dph_off == `FSU_OFF_INT_CLR) ? hwdata[1:0] : 2'b00;

  // Register file: subtract writeback beats load, load beats software
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_reg
      wire pipe_hit = pipe.valid && pipe.dest == 3'(gi);
      wire load_hit = load_wr && sel_move == 3'(gi);
      wire sw_hit   = sw_reg_wr && dph_off[4:2] == 3'(gi);

      assign next_rf[gi] = pipe_hit ? sub_res   :
                           load_hit ? load_data :
                           sw_hit   ? hwdata    :
                                      rf[gi];

      always_ff @(posedge core_clk)
      begin
        if (reset)
          rf[gi] <= 32'h0;
        else
          rf[gi] <= next_rf[gi];
      end
    end
  endgenerate

  // Load flag evaluation
  wire ld_exp_zero = load_data[30:23] == 8'h00;
  wire ld_nf       = load_data[31] && !ld_exp_zero;
  wire ld_zf       = ld_exp_zero;
  wire ld_ni       = load_data[31];
  wire ld_zi       = load_data == 32'h0;

  // Status register; hardware sets win over a software write
  always_comb
  begin
    next_stf = float_status_register;
    if (sw_stf_wr)
      next_stf = hwdata[10:0] & `FSU_STF_MASK;
    if (load_wr)
    begin
      next_stf[`FSU_BIT_NF] = ld_nf;
      next_stf[`FSU_BIT_ZF] = ld_zf;
      next_stf[`FSU_BIT_NI] = ld_ni;
      next_stf[`FSU_BIT_ZI] = ld_zi;
    end
    // Latched flags set by a subtract or by a software status write
    if (ev_ovf)
      next_stf[`FSU_BIT_LVF] = 1'b1;
    if (ev_unf)
      next_stf[`FSU_BIT_LUF] = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      float_status_register <= `FSU_STF_RESET;
    else
      float_status_register <= next_stf;
  end

  // Parallel store: register value goes out one cycle after issue
  always_comb
  begin
    next_store.valid = op == fsu_pkg::FSU_OP_STORE;
    next_store.mode  = mem_field;
    next_store.data  = rf[sel_move];
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      store <= '0;
    else
      store <= next_store;
  end

  // Interrupt status: set wins over a clear in the same cycle
  wire [1:0] events        = {ev_unf, ev_ovf};
  wire [1:0] next_int_stat = (int_stat & ~sw_clr) | events;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      int_stat <= 2'b00;
      int_en   <= 2'b00;
    end
    else
    begin
      int_stat <= next_int_stat;
      if (sw_en_wr)
        int_en <= hwdata[1:0];
    end
  end

  assign irq = |(int_stat & int_en);

  // Bus read mux; unmapped offsets read zero
  wire [31:0] rd_mux =
    dph_off <  `FSU_OFF_STATUS   ? rf[dph_off[4:2]]               :
    dph_off == `FSU_OFF_STATUS   ? {21'h0, float_status_register} :
    dph_off == `FSU_OFF_INT_STAT ? {30'h0, int_stat}              :
    dph_off == `FSU_OFF_INT_EN   ? {30'h0, int_en}                :
                                   32'h0;

  // Reads take one wait state so read data comes from a flop
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      dph_wr  <= 1'b0;
      dph_rd  <= 1'b0;
      rd_done <= 1'b0;
      dph_off <= 8'h00;
    end
    else if (addr_phase)
    begin
      dph_wr  <= hwrite;
      dph_rd  <= !hwrite;
      rd_done <= 1'b0;
      dph_off <= haddr[7:0];
    end
    else if (hready)
    begin
      dph_wr  <= 1'b0;
      dph_rd  <= 1'b0;
    end
    else if (dph_rd)
      rd_done <= 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      hrdata <= 32'h0;
    else if (dph_rd && !rd_done)
      hrdata <= rd_mux;
  end

  assign hreadyout = !(dph_rd && !rd_done);
  assign hresp     = 1'b0;

endmodule
`default_nettype wire

// >>> verilog/fsu_params.svh
// Constants for the floating-point subtract unit
`ifndef FSU_PARAMS_SVH
`define FSU_PARAMS_SVH

// Register offsets on the bus
`define FSU_OFF_REG0     8'h00
`define FSU_OFF_STATUS   8'h20
`define FSU_OFF_INT_STAT 8'h24
`define FSU_OFF_INT_CLR  8'h28
`define FSU_OFF_INT_EN   8'h2C

// Opcode patterns
`define FSU_LSW_RR       16'hE720
`define FSU_MSW_RR_ZERO  7'h00
`define FSU_IMM_TOP      10'h3A3
`define FSU_LOAD_TOP     12'hE32
`define FSU_STORE_TOP    12'hE02

// Status register bit positions, writable mask and reset value
`define FSU_BIT_LVF      0
`define FSU_BIT_LUF      1
`define FSU_BIT_NF       2
`define FSU_BIT_ZF       3
`define FSU_BIT_NI       4
`define FSU_BIT_ZI       5
`define FSU_BIT_TF       6
`define FSU_BIT_RND      9
`define FSU_STF_MASK     11'h27F
`define FSU_STF_RESET    11'h000

// Interrupt event bits
`define FSU_EV_OVF       0
`define FSU_EV_UNF       1

// Floating-point limits and bus word transfer size
`define FSU_EXP_INF      10'sd255
`define FSU_FP_MAX       31'h7F7FFFFF
`define FSU_SHIFT_MAX    8'h1A
`define FSU_AHB_WORD     3'h2

`endif

// >>> verilog/fsu_pkg.sv
// Types shared by the floating-point subtract unit
package fsu_pkg;

  typedef struct packed
  {
    logic [15:0] lsw;
    logic [15:0] msw;
  } fsu_instr_t;

  typedef enum logic [2:0]
  {
    FSU_OP_NONE  = 3'b000,
    FSU_OP_RR    = 3'b001,
    FSU_OP_IMM   = 3'b010,
    FSU_OP_LOAD  = 3'b011,
    FSU_OP_STORE = 3'b100
  } fsu_op_t;

  typedef struct packed
  {
    logic        valid;
    logic [2:0]  dest;
    logic [31:0] minuend;
    logic [31:0] subtrahend;
  } fsu_pipe_t;

  typedef struct packed
  {
    logic        valid;
    logic [7:0]  mode;
    logic [31:0] data;
  } fsu_store_t;

endpackage

// >>> sim/fsu_top_checker.sv
// Port assertions for the subtract unit
`timescale 1ns/10ps
`default_nettype none
module fsu_top_checker
(
  input wire logic                core_clk,
  input wire logic                reset,
  input wire logic                issue_valid,
  input wire fsu_pkg::fsu_instr_t instr,
  input wire logic [31:0]         load_data,
  input wire fsu_pkg::fsu_store_t store,
  input wire logic [10:0]         float_status_register,
  input wire logic                hsel,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  wire logic is_st  = issue_valid && instr.lsw[15:4] == 12'hE02;
  wire logic is_ld  = issue_valid && instr.lsw[15:4] == 12'hE32;
  wire logic is_sub = issue_valid && (instr.lsw[15:6] == 10'h3A3 ||
                      (instr.lsw == 16'hE720 && instr.msw[15:9] == 7'h00));
  wire logic [10:0] fsr = float_status_register;

  AST_STORE_PULSE: assert property (is_st |=> store.valid)
    else $error("store pulse missing");
  AST_STORE_CAUSE: assert property (store.valid |-> $past(is_st) &&
    store.mode == $past(instr.msw[7:0])) else $error("stray store pulse");
  AST_LOAD_NI: assert property (is_ld |=> fsr[4] == $past(load_data[31]))
    else $error("integer sign wrong");
  AST_LOAD_NF: assert property (is_ld |=> fsr[2] ==
    ($past(load_data[31]) && $past(load_data[30:23]) != 8'h00)) else $error("float sign wrong");
  AST_LOAD_ZF: assert property (is_ld |=> fsr[3] == ($past(load_data[30:23]) == 8'h00))
    else $error("float zero wrong");
  AST_LOAD_ZI: assert property (is_ld |=> fsr[5] == ($past(load_data) == 32'h0))
    else $error("integer zero wrong");
  AST_SUB_KEEP: assert property (is_sub ##1 !is_ld |=> $stable(fsr[6:2]))
    else $error("subtract touched other flags");
  AST_RSVD: assert property (fsr[10] == 1'b0 && fsr[8:7] == 2'h0)
    else $error("reserved status bit set");
  AST_LATCH: assert property (($fell(fsr[0]) || $fell(fsr[1])) |->
    $past(hsel && htrans[1] && hwrite, 2)) else $error("latched flag cleared");
  COV_LOAD: cover property (is_ld);
  COV_STORE: cover property (is_st);
  COV_OVF: cover property (fsr[0]);
endmodule
bind fsu_top fsu_top_checker chk_u (.core_clk, .reset, .issue_valid, .instr, .load_data,
  .store, .float_status_register, .hsel, .htrans, .hwrite);
`default_nettype wire

// >>> sim/fsu_host_mem.sv
// Host data memory feeding loads and taking stores
`timescale 1ns/10ps
`default_nettype none
module fsu_host_mem
(
  input  wire logic                core_clk,
  input  wire logic                issue_valid,
  input  wire fsu_pkg::fsu_instr_t instr,
  input  wire fsu_pkg::fsu_store_t store,
  output logic [31:0]              load_data
);
  logic [31:0] mem [256];
  wire logic   is_ld = issue_valid && instr.lsw[15:4] == 12'hE32;
  // Inverted off-cycle so a late sample cannot pass
  assign load_data = is_ld ? mem[instr.msw[7:0]] : ~mem[instr.msw[7:0]];
  always @(posedge core_clk)
    if (store.valid)
      mem[store.mode] <= store.data;
  initial
    for (int k = 0; k < 256; k++)
      mem[k] = 32'h0;
endmodule
`default_nettype wire

// >>> sim/fp_subtract_unit_tb.sv
// Directed bench: bus access, issue sequences, flags and interrupt
`timescale 1ns/10ps
`default_nettype none
module fp_subtract_unit_tb;
  logic                core_clk = 1'b0;
  logic                reset = 1'b1;
  logic                issue_valid = 1'b0;
  fsu_pkg::fsu_instr_t instr = '0;
  logic [31:0]         load_data;
  fsu_pkg::fsu_store_t store;
  logic [10:0]         float_status_register;
  logic                hsel = 1'b0;
  logic [31:0]         haddr = '0;
  logic [1:0]          htrans = '0;
  logic                hwrite = 1'b0;
  logic [2:0]          hsize = 3'h2;
  logic [31:0]         hwdata = '0;
  logic                hreadyout;
  logic                hresp;
  logic [31:0]         hrdata;
  logic                irq;
  logic [31:0]         e;
  logic [31:0]         vals [3] = '{32'h0, 32'h80000000, 32'hC0000000};
  int                  mismatches = 0;
  int                  n_checks = 0;
  always #5 core_clk = ~core_clk;
  fsu_top dut_u (.core_clk, .reset, .issue_valid, .instr, .load_data, .store,
    .float_status_register, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq);
  fsu_host_mem host_u (.core_clk, .issue_valid, .instr, .store, .load_data);

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Sample before the edge, so flop updates never race the read
  task automatic wt(output logic [31:0] d);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 40 && !r; i++)
    begin
      @(negedge core_clk);
      r = hreadyout;
      d = hrdata;
      @(posedge core_clk);
    end
    if (!r)
    begin
      mismatches++;
      conclude();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, wd, output logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wt(d);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wt(d);
  endtask
  task automatic wr(input logic [31:0] a, wd);
    logic [31:0] d;
    bus(1'b1, a, wd, d);
  endtask
  task automatic rd(input logic [31:0] a, x);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(d, x);
    chk({31'h0, hresp}, 32'h0);
  endtask
  // Idle delay slot after every issued instruction
  task automatic iss(input logic [15:0] l, m);
    issue_valid <= 1'b1;
    instr <= {l, m};
    @(posedge core_clk);
    issue_valid <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic irq_is(input logic x);
    @(negedge core_clk);
    chk({31'h0, irq}, {31'h0, x});
    @(posedge core_clk);
  endtask

  initial
  begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(32'h20, 32'h0);
    wr(32'h04, 32'h40400000);
    wr(32'h08, 32'h3F800000);
    iss(16'hE720, 16'h008B);
    rd(32'h0C, 32'h40000000);
    iss(16'hE8D0, 16'h000C);
    rd(32'h10, 32'hBF800000);
    $display("test arith done");
    wr(32'h14, 32'h7F7FFFFF);
    wr(32'h18, 32'hFF7FFFFF);
    iss(16'hE8DF, 16'hDFF0);
    rd(32'h00, 32'h7F7FFFFF);
    rd(32'h20, 32'h1);
    wr(32'h20, 32'h0);
    iss(16'hE720, 16'h01AF);
    rd(32'h1C, 32'h7F7FFFFF);
    rd(32'h20, 32'h1);
    wr(32'h00, 32'h00800001);
    wr(32'h08, 32'h00800000);
    iss(16'hE720, 16'h0086);
    rd(32'h18, 32'h0);
    iss(16'hE720, 16'h008B);
    rd(32'h20, 32'h3);
    rd(32'h24, 32'h3);
    wr(32'h2C, 32'h3);
    irq_is(1'b1);
    wr(32'h2C, 32'h0);
    irq_is(1'b0);
    wr(32'h2C, 32'h3);
    wr(32'h28, 32'h3);
    irq_is(1'b0);
    wr(32'h24, 32'h3);
    rd(32'h24, 32'h0);
    rd(32'h40, 32'h0);
    $display("test flags done");
    wr(32'h20, 32'h200);
    wr(32'h08, 32'h34000000);
    iss(16'hE720, 16'h008B);
    rd(32'h0C, 32'h40400000);
    wr(32'h20, 32'h0);
    for (int k = 0; k < 3; k++)
    begin
      host_u.mem[8'h10] = vals[k];
      iss(16'hE328, 16'h5E10);
      rd(32'h18, vals[k]);
      e = {26'h0, vals[k] == 32'h0, vals[k][31], vals[k][30:23] == 8'h00,
           vals[k][31] && vals[k][30:23] != 8'h00, 2'h0};
      rd(32'h20, e);
    end
    $display("test load done");
    iss(16'hE028, 16'h5C20);
    // Memory model writes on the edge the task returns at, so look later
    rd(32'h20, e);
    chk(host_u.mem[8'h20], 32'hBF800000);
    iss(16'hE720, 16'h008B);
    iss(16'hE028, 16'h5B24);
    rd(32'h0C, 32'h40800000);
    chk(host_u.mem[8'h24], 32'h403FFFFF);
    $display("test store done");
    conclude();
  end
endmodule
`default_nettype wire
